//--- dv/pif_event_src.sv
// partner model: peripheral event sources and comparator levels
`timescale 1ns/1ps
module pif_event_src (
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic [9:0] fire,
	output logic      [7:0] pulse,
	output logic            cmp_b,
	output logic            cmp_a
);
	// ========
	// one-cycle event pulses, comparator outputs toggle on request
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			pulse <= 8'h00;
			cmp_b <= 1'b0;
			cmp_a <= 1'b0;
		end else begin
			pulse <= fire[7:0];
			cmp_b <= cmp_b ^ fire[9];
			cmp_a <= cmp_a ^ fire[8];
		end
	end
endmodule : pif_event_src

//--- dv/pif_irq_assertions.sv
// checker: concurrent assertions on the ports of the interrupt flag block
`timescale 1ns/1ps
module pif_irq_assertions #(
	parameter int ADDR_W = 8
) (
	input wire logic        clock,
	input wire logic        reset_n,
	input wire logic        clk_en,
	input wire logic        s_axil_awvalid,
	input wire logic        s_axil_awready,
	input wire logic        s_axil_wvalid,
	input wire logic        s_axil_wready,
	input wire logic        s_axil_bvalid,
	input wire logic        s_axil_bready,
	input wire logic [1:0]  s_axil_bresp,
	input wire logic        s_axil_arvalid,
	input wire logic        s_axil_arready,
	input wire logic        s_axil_rvalid,
	input wire logic        s_axil_rready,
	input wire logic [31:0] s_axil_rdata,
	input wire logic        global_irq_enable,
	input wire logic        peripheral_group_enable,
	input wire logic [7:0]  periph_irq_enable_first,
	input wire logic        wide_timer_gate_event,
	input wire logic        conversion_done_event,
	input wire logic        limit_timer_b_match,
	input wire logic        limit_timer_a_match,
	input wire logic        period_timer_match,
	input wire logic        wide_timer_rollover,
	input wire logic        periph_irq_request
);
	logic [7:0] ev1;
	logic       go;
	logic       idle;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	// ========
	// first flag register events, both enables, write channels quiet
	assign ev1  = {wide_timer_gate_event, conversion_done_event, 2'b00, limit_timer_b_match,
		limit_timer_a_match, period_timer_match, wide_timer_rollover};
	assign go   = global_irq_enable && peripheral_group_enable;
	assign idle = s_axil_awready && s_axil_wready && !s_axil_awvalid && !s_axil_wvalid;

	global_gate_a: assert property (!global_irq_enable |=> !periph_irq_request)
		else $error("request high after global enable low");
	group_gate_a: assert property (!peripheral_group_enable |=> !periph_irq_request)
		else $error("request high after group enable low");
	event_raise_a: assert property ((go && |(ev1 & periph_irq_enable_first)) ##1
		(go && $stable(periph_irq_enable_first)) |=> periph_irq_request)
		else $error("enabled event did not raise request");
	sticky_hold_a: assert property (periph_irq_request && go && idle && $stable(go) &&
		$stable(periph_irq_enable_first) |=> periph_irq_request)
		else $error("request dropped without a write");
	bresp_hold_a: assert property (s_axil_bvalid && !s_axil_bready && clk_en |=>
		s_axil_bvalid && $stable(s_axil_bresp)) else $error("write response not held");
	rdata_hold_a: assert property (s_axil_rvalid && !s_axil_rready |=>
		s_axil_rvalid && $stable(s_axil_rdata)) else $error("read data not held");
	read_answer_a: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
		else $error("read answer late");
	upper_zero_a: assert property (s_axil_rvalid |-> s_axil_rdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
endmodule : pif_irq_assertions

bind pif_irq_top pif_irq_assertions #(.ADDR_W(ADDR_W)) i_pif_irq_assertions (
	.clock, .reset_n, .clk_en, .s_axil_awvalid, .s_axil_awready, .s_axil_wvalid,
	.s_axil_wready, .s_axil_bvalid, .s_axil_bready, .s_axil_bresp, .s_axil_arvalid,
	.s_axil_arready, .s_axil_rvalid, .s_axil_rready, .s_axil_rdata, .global_irq_enable,
	.peripheral_group_enable, .periph_irq_enable_first, .wide_timer_gate_event,
	.conversion_done_event, .limit_timer_b_match, .limit_timer_a_match,
	.period_timer_match, .wide_timer_rollover, .periph_irq_request
);

//--- dv/pif_irq_top_test.sv
// testbench: register access, event flags and request gating
`timescale 1ns/1ps
module pif_irq_top_test;
	localparam logic [7:0] EN2 = {4'h0, pif_pkg::OFS_ENABLE_SECOND};
	localparam logic [7:0] F1  = {4'h0, pif_pkg::OFS_FLAGS_FIRST};
	localparam logic [7:0] F2  = {4'h0, pif_pkg::OFS_FLAGS_SECOND};
	localparam logic [7:0] ST  = {4'h0, pif_pkg::OFS_IRQ_STATUS};
	localparam logic [7:0] ADR [4] = '{EN2, F1, F2, ST};
	localparam logic [7:0] MSK [3] = '{pif_pkg::MASK_ENABLE_SECOND,
		pif_pkg::MASK_FLAGS_FIRST, pif_pkg::MASK_FLAGS_SECOND};
	logic        clock = 1'b0;
	logic        reset_n = 1'b0;
	logic        s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
	logic        s_axil_arvalid = 1'b0, s_axil_rready = 1'b0;
	logic [7:0]  s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
	logic [31:0] s_axil_wdata = 32'h00000000;
	logic        s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
	logic [1:0]  s_axil_bresp, s_axil_rresp;
	logic [31:0] s_axil_rdata;
	logic        global_irq_enable = 1'b0, peripheral_group_enable = 1'b0;
	logic [7:0]  periph_irq_enable_first = 8'h00;
	logic [1:0]  capture_compare_mode = 2'h0;
	logic [9:0]  fire = 10'h000;
	logic [7:0]  pulse, fa, fe;
	logic        cmp_b, cmp_a, periph_irq_request;
	logic [31:0] rd;
	logic [1:0]  rs;
	int          miscompares = 0, n_checks = 0;

	always #5 clock = ~clock;

	pif_irq_top i_pif_irq_top (
		.clock, .reset_n, .clk_en(1'b1),
		.s_axil_awvalid, .s_axil_awready, .s_axil_awaddr, .s_axil_awprot(3'h0),
		.s_axil_wvalid, .s_axil_wready, .s_axil_wdata, .s_axil_wstrb(4'hF),
		.s_axil_bvalid, .s_axil_bready, .s_axil_bresp,
		.s_axil_arvalid, .s_axil_arready, .s_axil_araddr, .s_axil_arprot(3'h0),
		.s_axil_rvalid, .s_axil_rready, .s_axil_rdata, .s_axil_rresp,
		.global_irq_enable, .peripheral_group_enable, .periph_irq_enable_first,
		.wide_timer_gate_event(pulse[7]), .conversion_done_event(pulse[6]),
		.limit_timer_b_match(pulse[3]), .limit_timer_a_match(pulse[2]),
		.period_timer_match(pulse[1]), .wide_timer_rollover(pulse[0]),
		.output_generator_shutdown(pulse[5]), .capture_compare_event(pulse[4]),
		.capture_compare_mode, .comparator_b_output(cmp_b), .comparator_a_output(cmp_a),
		.periph_irq_request
	);
	pif_event_src i_pif_event_src (.clock, .reset_n, .fire, .pulse, .cmp_b, .cmp_a);

	// ========
	// compare, bus cycles, event firing, verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask : chk

	// late holds bready or rready low until the answer shows, to make the slave hold it
	task automatic axw(input logic [7:0] a, input logic [7:0] d, input bit late = 1'b0);
		@(posedge clock);
		s_axil_awaddr  <= a;
		s_axil_wdata   <= {24'h000000, d};
		s_axil_awvalid <= 1'b1;
		s_axil_wvalid  <= 1'b1;
		s_axil_bready  <= !late;
		do begin
			@(posedge clock);
			if (s_axil_awready) s_axil_awvalid <= 1'b0;
			if (s_axil_wready) s_axil_wvalid <= 1'b0;
			if (s_axil_bvalid && !s_axil_bready) s_axil_bready <= 1'b1;
			rs = s_axil_bresp;
		end while (!(s_axil_bvalid && s_axil_bready));
		s_axil_bready <= 1'b0;
	endtask : axw

	task automatic axr(input logic [7:0] a, input bit late = 1'b0);
		@(posedge clock);
		s_axil_araddr  <= a;
		s_axil_arvalid <= 1'b1;
		s_axil_rready  <= !late;
		do begin
			@(posedge clock);
			if (s_axil_arready) s_axil_arvalid <= 1'b0;
			if (s_axil_rvalid && !s_axil_rready) s_axil_rready <= 1'b1;
			rd = s_axil_rdata;
			rs = s_axil_rresp;
		end while (!(s_axil_rvalid && s_axil_rready));
		s_axil_rready <= 1'b0;
	endtask : axr

	task automatic ev(input int i);
		@(posedge clock);
		fire <= 10'h001 << i;
		@(posedge clock);
		fire <= 10'h000;
		repeat (6) @(posedge clock);
	endtask : ev

	task automatic conclude();
		$display("checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : conclude

	// watchdog against a hung handshake
	initial begin
		repeat (5000) @(posedge clock);
		miscompares++;
		conclude();
	end

	initial begin
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		for (int j = 0; j < 4; j++) begin
			axr(ADR[j]);
			chk(rd, 32'h00000000);
		end
		axr(8'h10);
		chk({30'h0, rs}, {30'h0, pif_pkg::RESP_SLVERR});
		chk(rd, 32'h00000000);
		$display("test reset values done");
		for (int j = 0; j < 3; j++) begin
			axw(ADR[j], 8'hFF, j[0]);
			axr(ADR[j], j[1]);
			chk(rd, {24'h000000, MSK[j]});
			axw(ADR[j], 8'h00);
			axr(ADR[j]);
			chk(rd, 32'h00000000);
		end
		$display("test register access done");
		for (int i = 0; i < 10; i++) begin
			fa = (i inside {4, 5, 8, 9}) ? F2 : F1;
			fe = (i == 4) ? 8'h01 : (i == 5) ? 8'h04 : (i >= 8) ? 8'h10 << (i - 8) : 8'h01 << i;
			ev(i);
			axr(fa);
			chk(rd, {24'h000000, fe});
			axw(fa, 8'h00);
		end
		$display("test event flags done");
		for (int m = 0; m < 4; m++) begin
			capture_compare_mode <= 2'(m);
			ev(4);
			axr(F2);
			chk(rd, (m < 2) ? 32'h00000001 : 32'h00000000);
			axw(F2, 8'h00);
		end
		capture_compare_mode <= pif_pkg::CCP_CAPTURE;
		$display("test capture compare modes done");
		axw(F1, 8'h02);
		fork
			axw(F1, 8'h00);
			ev(0);
		join
		axr(F1);
		chk(rd, 32'h00000001);
		$display("test set over clear done");
		for (int k = 0; k < 8; k++) begin
			periph_irq_enable_first <= {7'h00, k[2]};
			global_irq_enable <= k[0];
			peripheral_group_enable <= k[1];
			repeat (3) @(posedge clock);
			chk({31'h0, periph_irq_request}, (k == 7) ? 32'h1 : 32'h0);
		end
		axr(ST);
		chk(rd, 32'h00000003);
		axw(F1, 8'h00);
		axw(F2, 8'h00);
		axw(EN2, 8'h01);
		chk({31'h0, periph_irq_request}, 32'h0);
		ev(4);
		chk({31'h0, periph_irq_request}, 32'h1);
		axw(F2, 8'h00);
		@(posedge clock);
		chk({31'h0, periph_irq_request}, 32'h0);
		ev(0);
		chk({31'h0, periph_irq_request}, 32'h1);
		$display("test interrupt gating done");
		conclude();
	end
endmodule : pif_irq_top_test

//--- hw/pif_flag_reg.sv
// module: sticky flag register, software overwrite, hardware set wins
`timescale 1ns/1ps
module pif_flag_reg #(
	parameter logic [7:0] MASK = 8'hFF
) (
	input  wire logic   clock,
	input  wire logic   reset_n,
	input  wire logic   clk_en,
	pif_flag_if.store   port
);
	logic [pif_pkg::REG_W-1:0] flags;
	logic [pif_pkg::REG_W-1:0] next_flags;

	// ============================================================================
	// parameter check
	if (MASK == 8'h00) begin : g_chk
		$error("pif_flag_reg: MASK selects no bit");
	end

	// write overwrites, events set on top, dead bits forced low
	always_comb begin
		next_flags = flags;
		if (port.wr) begin
			next_flags = port.wdata;
		end
		next_flags = (next_flags | port.set) & MASK;
	end

	// register only
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			flags <= pif_pkg::RST_REG;
		end else if (clk_en) begin
			flags <= next_flags;
		end
	end

	assign port.value = flags;
endmodule : pif_flag_reg

//--- hw/pif_irq_top.sv
// module: peripheral interrupt enables and flags behind an AXI4-Lite slave
`timescale 1ns/1ps
module pif_irq_top #(
	parameter int ADDR_W = 8
) (
	input  wire logic              clock,
	input  wire logic              reset_n,
	input  wire logic              clk_en,
	// AXI4-Lite write address channel
	input  wire logic              s_axil_awvalid,
	output logic                   s_axil_awready,
	input  wire logic [ADDR_W-1:0] s_axil_awaddr,
	input  wire logic [2:0]        s_axil_awprot,
	// AXI4-Lite write data channel
	input  wire logic              s_axil_wvalid,
	output logic                   s_axil_wready,
	input  wire logic [31:0]       s_axil_wdata,
	input  wire logic [3:0]        s_axil_wstrb,
	// AXI4-Lite write response channel
	output logic                   s_axil_bvalid,
	input  wire logic              s_axil_bready,
	output logic      [1:0]        s_axil_bresp,
	// AXI4-Lite read address channel
	input  wire logic              s_axil_arvalid,
	output logic                   s_axil_arready,
	input  wire logic [ADDR_W-1:0] s_axil_araddr,
	input  wire logic [2:0]        s_axil_arprot,
	// AXI4-Lite read data channel
	output logic                   s_axil_rvalid,
	input  wire logic              s_axil_rready,
	output logic      [31:0]       s_axil_rdata,
	output logic      [1:0]        s_axil_rresp,
	// core control and first enable register, held outside
	input  wire logic              global_irq_enable,
	input  wire logic              peripheral_group_enable,
	input  wire logic [7:0]        periph_irq_enable_first,
	// peripheral events, one-cycle pulses on this clock
	input  wire logic              wide_timer_gate_event,
	input  wire logic              conversion_done_event,
	input  wire logic              limit_timer_b_match,
	input  wire logic              limit_timer_a_match,
	input  wire logic              period_timer_match,
	input  wire logic              wide_timer_rollover,
	input  wire logic              output_generator_shutdown,
	input  wire logic              capture_compare_event,
	input  wire logic [1:0]        capture_compare_mode,
	// comparator outputs, asynchronous levels
	input  wire logic              comparator_b_output,
	input  wire logic              comparator_a_output,
	// request towards the core
	output logic                   periph_irq_request
);

	// ============================================================================
	// states and parameter check
	typedef enum logic [1:0] {
		PIF_W_IDLE = 2'b01,
		PIF_W_RESP = 2'b10
	} pif_wr_state_t;

	typedef enum logic [1:0] {
		PIF_R_IDLE = 2'b01,
		PIF_R_DATA = 2'b10
	} pif_rd_state_t;

	if (ADDR_W < 5 || ADDR_W > 32) begin : g_chk
		$error("pif_irq_top: ADDR_W must lie in 5..32");
	end

	// ============================================================================
	// address decode, shared by the write and read paths
	// returns one-hot {status, flags second, flags first, enable second}, zero if unmapped
	function automatic logic [3:0] pif_reg_sel(input logic [ADDR_W-1:0] addr);
		logic [3:0] sel;
		sel = 4'h0;
		if (addr[ADDR_W-1:4] == '0) begin
			case (addr[3:0])
				pif_pkg::OFS_ENABLE_SECOND: sel = 4'h1;
				pif_pkg::OFS_FLAGS_FIRST:   sel = 4'h2;
				pif_pkg::OFS_FLAGS_SECOND:  sel = 4'h4;
				pif_pkg::OFS_IRQ_STATUS:    sel = 4'h8;
				default:                    sel = 4'h0;
			endcase
		end
		return sel;
	endfunction : pif_reg_sel

	// ============================================================================
	// declarations
	pif_wr_state_t wstate;
	pif_wr_state_t next_wstate;
	pif_rd_state_t rstate;
	pif_rd_state_t next_rstate;

	logic              aw_held;
	logic              next_aw_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [ADDR_W-1:0] next_aw_addr;
	logic              w_held;
	logic              next_w_held;
	logic [7:0]        w_byte;
	logic [7:0]        next_w_byte;
	logic              w_lane;
	logic              next_w_lane;
	logic [1:0]        bresp;
	logic [1:0]        next_bresp;
	logic [31:0]       rdata;
	logic [31:0]       next_rdata;
	logic [1:0]        rresp;
	logic [1:0]        next_rresp;

	logic              wr_fire;
	logic [3:0]        wr_sel;
	logic [3:0]        rd_sel;
	logic              wr_go;

	logic [7:0]        enable_second;
	logic [7:0]        next_enable_second;
	logic [7:0]        set_first;
	logic [7:0]        set_second;
	logic [1:0]        cmp_change;
	logic              any_pending;
	logic              irq;
	logic              next_irq;

	pif_flag_if flags_first_if ();
	pif_flag_if flags_second_if ();

	// ============================================================================
	// comparator output change detection
	pif_sync_change #(
		.W (2)
	) u_cmp_sync (
		.clock    (clock),
		.reset_n  (reset_n),
		.clk_en   (clk_en),
		.level_in ({comparator_b_output, comparator_a_output}),
		.change   (cmp_change)
	);

	// ============================================================================
	// event collection; each flag sets regardless of the interrupt enables, but only while clk_en is high
	always_comb begin
		set_first                        = 8'h00;
		set_first[pif_pkg::POS_GATE]     = wide_timer_gate_event;
		set_first[pif_pkg::POS_CONV]     = conversion_done_event;
		set_first[pif_pkg::POS_LIMIT_B]  = limit_timer_b_match;
		set_first[pif_pkg::POS_LIMIT_A]  = limit_timer_a_match;
		set_first[pif_pkg::POS_PERIOD]   = period_timer_match;
		set_first[pif_pkg::POS_ROLLOVER] = wide_timer_rollover;
		set_first                        = set_first & {8{clk_en}};
	end

	// second group; the ccp event counts only in capture or compare mode
	always_comb begin
		set_second                      = 8'h00;
		set_second[pif_pkg::POS_CMP_B]  = cmp_change[1];
		set_second[pif_pkg::POS_CMP_A]  = cmp_change[0];
		set_second[pif_pkg::POS_GEN]    = output_generator_shutdown;
		set_second[pif_pkg::POS_CCP]    = capture_compare_event
			&& (capture_compare_mode == pif_pkg::CCP_CAPTURE
			|| capture_compare_mode == pif_pkg::CCP_COMPARE);
		set_second                      = set_second & {8{clk_en}};
	end

	// ============================================================================
	// sticky flag registers
	assign wr_sel  = pif_reg_sel(aw_addr);
	assign wr_go   = wr_fire && w_lane;

	// software writes reach the flags only through byte lane 0
	assign flags_first_if.set    = set_first;
	assign flags_first_if.wr     = wr_go && wr_sel[1];
	assign flags_first_if.wdata  = w_byte;
	assign flags_second_if.set   = set_second;
	assign flags_second_if.wr    = wr_go && wr_sel[2];
	assign flags_second_if.wdata = w_byte;

	pif_flag_reg #(
		.MASK (pif_pkg::MASK_FLAGS_FIRST)
	) u_flags_first (
		.clock   (clock),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.port    (flags_first_if.store)
	);

	pif_flag_reg #(
		.MASK (pif_pkg::MASK_FLAGS_SECOND)
	) u_flags_second (
		.clock   (clock),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.port    (flags_second_if.store)
	);

	// ============================================================================
	// second enable register
	// unimplemented positions are never stored, so they read zero
	always_comb begin
		next_enable_second = enable_second;
		if (wr_go && wr_sel[0]) begin
			next_enable_second = w_byte & pif_pkg::MASK_ENABLE_SECOND;
		end
	end

	// register only
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			enable_second <= pif_pkg::RST_REG;
		end else if (clk_en) begin
			enable_second <= next_enable_second;
		end
	end

	// ============================================================================
	// interrupt request towards the core
	// software is expected to clear stale flags before enabling them
	always_comb begin
		any_pending = |(flags_first_if.value & periph_irq_enable_first)
			| |(flags_second_if.value & enable_second);
		next_irq    = global_irq_enable
			&& peripheral_group_enable
			&& any_pending;
	end

	// register only, request is a level
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= next_irq;
		end
	end

	assign periph_irq_request = irq;

	// ============================================================================
	// write path: address and data taken in either order, then one response
	always_comb begin
		next_wstate  = wstate;
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held  = w_held;
		next_w_byte  = w_byte;
		next_w_lane  = w_lane;
		next_bresp   = bresp;
		wr_fire      = 1'b0;
		if (s_axil_awvalid && s_axil_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axil_awaddr;
		end
		if (s_axil_wvalid && s_axil_wready) begin
			next_w_held = 1'b1;
			next_w_byte = s_axil_wdata[7:0];
			next_w_lane = s_axil_wstrb[0];
		end
		case (wstate)
			PIF_W_IDLE: begin
				if (aw_held && w_held && clk_en) begin
					wr_fire      = 1'b1;
					next_aw_held = 1'b0;
					next_w_held  = 1'b0;
					next_bresp   = (wr_sel == 4'h0) ? pif_pkg::RESP_SLVERR
						: pif_pkg::RESP_OKAY;
					next_wstate  = PIF_W_RESP;
				end
			end
			PIF_W_RESP: begin
				if (s_axil_bvalid && s_axil_bready) begin
					next_wstate = PIF_W_IDLE;
				end
			end
			default: begin
				next_wstate = PIF_W_IDLE;
			end
		endcase
	end

	// register only
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			wstate  <= PIF_W_IDLE;
			aw_held <= 1'b0;
			aw_addr <= '0;
			w_held  <= 1'b0;
			w_byte  <= 8'h00;
			w_lane  <= 1'b0;
			bresp   <= pif_pkg::RESP_OKAY;
		end else if (clk_en) begin
			wstate  <= next_wstate;
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held  <= next_w_held;
			w_byte  <= next_w_byte;
			w_lane  <= next_w_lane;
			bresp   <= next_bresp;
		end
	end

	// handshakes are frozen with the rest while clk_en is low
	assign s_axil_awready = clk_en && !aw_held && (wstate == PIF_W_IDLE);
	assign s_axil_wready  = clk_en && !w_held && (wstate == PIF_W_IDLE);
	assign s_axil_bvalid  = clk_en && (wstate == PIF_W_RESP);
	assign s_axil_bresp   = bresp;

	// ============================================================================
	// read path: data sampled at the address handshake
	assign rd_sel = pif_reg_sel(s_axil_araddr);

	always_comb begin
		next_rstate = rstate;
		next_rdata  = rdata;
		next_rresp  = rresp;
		case (rstate)
			PIF_R_IDLE: begin
				if (s_axil_arvalid && s_axil_arready) begin
					next_rdata  = 32'h0000_0000;
					next_rresp  = pif_pkg::RESP_OKAY;
					case (rd_sel)
						4'h1: next_rdata[7:0] = enable_second;
						4'h2: next_rdata[7:0] = flags_first_if.value;
						4'h4: next_rdata[7:0] = flags_second_if.value;
						4'h8: begin
							next_rdata[pif_pkg::POS_ST_REQ] = irq;
							next_rdata[pif_pkg::POS_ST_ANY] = any_pending;
						end
						default: next_rresp = pif_pkg::RESP_SLVERR;
					endcase
					next_rstate = PIF_R_DATA;
				end
			end
			PIF_R_DATA: begin
				if (s_axil_rvalid && s_axil_rready) begin
					next_rstate = PIF_R_IDLE;
				end
			end
			default: begin
				next_rstate = PIF_R_IDLE;
			end
		endcase
	end

	// register only
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rstate <= PIF_R_IDLE;
			rdata  <= 32'h0000_0000;
			rresp  <= pif_pkg::RESP_OKAY;
		end else if (clk_en) begin
			rstate <= next_rstate;
			rdata  <= next_rdata;
			rresp  <= next_rresp;
		end
	end

	assign s_axil_arready = clk_en && (rstate == PIF_R_IDLE);
	assign s_axil_rvalid  = clk_en && (rstate == PIF_R_DATA);
	assign s_axil_rdata   = rdata;
	assign s_axil_rresp   = rresp;

endmodule : pif_irq_top

//--- hw/pif_sync_change.sv
// module: two-flop synchroniser with change detection for comparator outputs
`timescale 1ns/1ps
module pif_sync_change #(
	parameter int W = 2
) (
	input  wire logic         clock,
	input  wire logic         reset_n,
	input  wire logic         clk_en,
	input  wire logic [W-1:0] level_in,
	output logic      [W-1:0] change
);
	logic [W-1:0]                  meta;
	logic [W-1:0]                  sync;
	logic [W-1:0]                  prev;
	logic [pif_pkg::SYNC_FILL-1:0] fill;
	logic [pif_pkg::SYNC_FILL-1:0] next_fill;

	// ============================================================================
	// parameter check
	if (W < 1) begin : g_chk
		$error("pif_sync_change: W must be at least 1");
	end

	// fill marks when prev holds a genuine sample
	always_comb begin
		next_fill = {fill[pif_pkg::SYNC_FILL-2:0], 1'b1};
	end

	// meta feeds only sync
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			meta <= '0;
			sync <= '0;
			prev <= '0;
			fill <= '0;
		end else if (clk_en) begin
			meta <= level_in;
			sync <= meta;
			prev <= sync;
			fill <= next_fill;
		end
	end

	// any edge of the output counts
	assign change = (sync ^ prev) & {W{fill[pif_pkg::SYNC_FILL-1] & clk_en}};
endmodule : pif_sync_change

//--- pkg/pif_flag_if.sv
// interface: carrier between the register slave and one sticky flag register
`timescale 1ns/1ps
interface pif_flag_if;
	logic [pif_pkg::REG_W-1:0] set;
	logic                      wr;
	logic [pif_pkg::REG_W-1:0] wdata;
	logic [pif_pkg::REG_W-1:0] value;

	// ============================================================================
	// flag store side and controlling side
	modport store (input set, input wr, input wdata, output value);
	modport ctrl  (output set, output wr, output wdata, input value);
endinterface : pif_flag_if

//--- pkg/pif_pkg.sv
// package: register map, field layout and constants of the peripheral interrupt flags
// ============================================================================
package pif_pkg;

	// ============================================================================
	// register map (byte offsets within the slave window)
	localparam int         REG_W             = 8;
	localparam logic [3:0] OFS_ENABLE_SECOND = 4'h0;
	localparam logic [3:0] OFS_FLAGS_FIRST   = 4'h4;
	localparam logic [3:0] OFS_FLAGS_SECOND  = 4'h8;
	localparam logic [3:0] OFS_IRQ_STATUS    = 4'hC;

	// ============================================================================
	// field positions
	localparam int POS_CMP_B     = 5;
	localparam int POS_CMP_A     = 4;
	localparam int POS_GEN       = 2;
	localparam int POS_CCP       = 0;
	localparam int POS_GATE      = 7;
	localparam int POS_CONV      = 6;
	localparam int POS_LIMIT_B   = 3;
	localparam int POS_LIMIT_A   = 2;
	localparam int POS_PERIOD    = 1;
	localparam int POS_ROLLOVER  = 0;
	localparam int POS_ST_REQ    = 0;
	localparam int POS_ST_ANY    = 1;

	// ============================================================================
	// implemented bits and reset values
	localparam logic [7:0] MASK_ENABLE_SECOND = 8'h35;
	localparam logic [7:0] MASK_FLAGS_FIRST   = 8'hCF;
	localparam logic [7:0] MASK_FLAGS_SECOND  = 8'h35;
	localparam logic [7:0] RST_REG            = 8'h00;

	// ============================================================================
	// capture/compare unit modes and bus responses
	localparam logic [1:0] CCP_CAPTURE = 2'h0;
	localparam logic [1:0] CCP_COMPARE = 2'h1;
	localparam logic [1:0] CCP_PWM     = 2'h2;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int         SYNC_FILL   = 3;

endpackage : pif_pkg
